// *** hw/io_port_pkg.sv ***
package io_port_pkg;

   // register offsets in the 8-bit port space
   localparam logic [7:0] PORT0_DATA_ADDR = 8'h00;
   localparam logic [7:0] PORT1_DATA_ADDR = 8'h01;
   localparam logic [7:0] PORT2_DATA_ADDR = 8'h02;
   localparam logic [7:0] PORT3_DATA_ADDR = 8'h03;
   localparam logic [7:0] PORT0_IRQ_ENABLE_ADDR = 8'h04;
   localparam logic [7:0] PORT1_IRQ_ENABLE_ADDR = 8'h05;
   localparam logic [7:0] PORT2_IRQ_ENABLE_ADDR = 8'h06;
   localparam logic [7:0] PORT3_IRQ_ENABLE_ADDR = 8'h07;
   localparam logic [7:0] PORT_CONFIGURATION_ADDR = 8'h08;
   localparam logic [7:0] SERIAL_PIN_POSITION_CONFIG_ADDR = 8'h09;
   localparam logic [7:0] DEVICE_ADDRESS_FIRST_ADDR = 8'h10;
   localparam logic [7:0] FIRST_EP0_COUNT_ADDR = 8'h11;
   localparam logic [7:0] FIRST_EP0_MODE_ADDR = 8'h12;
   localparam logic [7:0] FIRST_EP1_COUNT_ADDR = 8'h13;
   localparam logic [7:0] FIRST_EP1_MODE_ADDR = 8'h14;
   localparam logic [7:0] FIRST_EP2_COUNT_ADDR = 8'h15;
   localparam logic [7:0] FIRST_EP2_MODE_ADDR = 8'h16;
   localparam logic [7:0] UPSTREAM_STATUS_CONTROL_ADDR = 8'h1f;
   localparam logic [7:0] GLOBAL_IRQ_ENABLE_ADDR = 8'h20;
   localparam logic [7:0] ENDPOINT_IRQ_ENABLE_ADDR = 8'h21;
   localparam logic [7:0] PENDING_VECTOR_ADDR = 8'h23;
   localparam logic [7:0] TIMER_LOW_BYTE_ADDR = 8'h24;
   localparam logic [7:0] TIMER_HIGH_NIBBLE_ADDR = 8'h25;
   localparam logic [7:0] WATCHDOG_RESTART_ADDR = 8'h26;
   localparam logic [7:0] SERIAL_CTRL_STATUS_ADDR = 8'h28;
   localparam logic [7:0] SERIAL_DATA_ADDR = 8'h29;
   localparam logic [7:0] DEVICE_ADDRESS_SECOND_ADDR = 8'h40;
   localparam logic [7:0] SECOND_EP0_COUNT_ADDR = 8'h41;
   localparam logic [7:0] SECOND_EP0_MODE_ADDR = 8'h42;
   localparam logic [7:0] SECOND_EP1_COUNT_ADDR = 8'h43;
   localparam logic [7:0] SECOND_EP1_MODE_ADDR = 8'h44;
   localparam logic [7:0] DOWNSTREAM_CONNECT_STATUS_ADDR = 8'h48;
   localparam logic [7:0] DOWNSTREAM_PORT_ENABLE_ADDR = 8'h49;
   localparam logic [7:0] DOWNSTREAM_PORT_SPEED_ADDR = 8'h4a;
   localparam logic [7:0] DOWNSTREAM_CONTROL_LOW_PORTS_ADDR = 8'h4b;
   localparam logic [7:0] DOWNSTREAM_CONTROL_HIGH_PORTS_ADDR = 8'h4c;
   localparam logic [7:0] DOWNSTREAM_SUSPEND_CONTROL_ADDR = 8'h4d;
   localparam logic [7:0] DOWNSTREAM_RESUME_STATUS_ADDR = 8'h4e;
   localparam logic [7:0] DOWNSTREAM_SINGLE_ENDED_ZERO_ADDR = 8'h4f;
   localparam logic [7:0] DOWNSTREAM_LINE_DATA_ADDR = 8'h50;
   localparam logic [7:0] DOWNSTREAM_DRIVE_LOW_ADDR = 8'h51;
   localparam logic [7:0] DOWNSTREAM_DRIVE_HIGH_ADDR = 8'h52;
   localparam logic [7:0] PROCESSOR_STATUS_CONTROL_ADDR = 8'hff;

   // reset value of every stored register
   localparam logic [7:0] REGISTER_RESET_VALUE = 8'h00;
   localparam logic [3:0] TIMER_HOLD_RESET_VALUE = 4'h0;

   // storage slots: writable registers held in this block
   localparam int NUM_SLOTS = 36;
   localparam logic [7:0] SLOT_ADDR [NUM_SLOTS] = '{
      PORT0_DATA_ADDR, PORT1_DATA_ADDR, PORT2_DATA_ADDR, PORT3_DATA_ADDR,
      PORT0_IRQ_ENABLE_ADDR, PORT1_IRQ_ENABLE_ADDR, PORT2_IRQ_ENABLE_ADDR,
      PORT3_IRQ_ENABLE_ADDR, PORT_CONFIGURATION_ADDR, SERIAL_PIN_POSITION_CONFIG_ADDR,
      DEVICE_ADDRESS_FIRST_ADDR, FIRST_EP0_COUNT_ADDR, FIRST_EP0_MODE_ADDR,
      FIRST_EP1_COUNT_ADDR, FIRST_EP1_MODE_ADDR, FIRST_EP2_COUNT_ADDR,
      FIRST_EP2_MODE_ADDR, UPSTREAM_STATUS_CONTROL_ADDR, GLOBAL_IRQ_ENABLE_ADDR,
      ENDPOINT_IRQ_ENABLE_ADDR, SERIAL_CTRL_STATUS_ADDR, SERIAL_DATA_ADDR,
      DEVICE_ADDRESS_SECOND_ADDR, SECOND_EP0_COUNT_ADDR, SECOND_EP0_MODE_ADDR,
      SECOND_EP1_COUNT_ADDR, SECOND_EP1_MODE_ADDR, DOWNSTREAM_CONNECT_STATUS_ADDR,
      DOWNSTREAM_PORT_ENABLE_ADDR, DOWNSTREAM_PORT_SPEED_ADDR,
      DOWNSTREAM_CONTROL_LOW_PORTS_ADDR, DOWNSTREAM_CONTROL_HIGH_PORTS_ADDR,
      DOWNSTREAM_SUSPEND_CONTROL_ADDR, DOWNSTREAM_DRIVE_LOW_ADDR,
      DOWNSTREAM_DRIVE_HIGH_ADDR, PROCESSOR_STATUS_CONTROL_ADDR};

   // slot numbers read back by name
   localparam int SLOT_PORT0_IRQ_ENABLE = 4;
   localparam int SLOT_PORT3_IRQ_ENABLE = 7;
   localparam int SLOT_DEVICE_ADDRESS_SECOND = 22;
   localparam int SLOT_SECOND_EP0_MODE = 24;
   localparam int SLOT_SECOND_EP1_MODE = 26;
   localparam int SLOT_CONTROL_LOW_PORTS = 30;
   localparam int SLOT_CONTROL_HIGH_PORTS = 31;
   localparam int SLOT_DRIVE_LOW = 33;
   localparam int SLOT_DRIVE_HIGH = 34;
   localparam int SLOT_PROCESSOR_STATUS = 35;

endpackage

// *** hw/io_port_address_decoder.sv ***
`timescale 1ns/10ps

module io_port_address_decoder
   import io_port_pkg::*;
(
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_RESETN,
   // core instruction side
   input wire logic I_PORT_READ_INSTRUCTION,
   input wire logic I_PORT_WRITE_INSTRUCTION,
   input wire logic I_INDEXED_PORT_WRITE_INSTRUCTION,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_INDEX,
   input wire logic [7:0] I_ACC,
   output logic [7:0] O_RDATA,
   output logic O_RDATA_VALID,
   // peripheral status, same clock
   input wire logic [7:0] I_PENDING_VECTOR,
   input wire logic [11:0] I_TIMER,
   input wire logic [7:0] I_RESUME_STATUS,
   input wire logic [7:0] I_SINGLE_ENDED_ZERO,
   input wire logic [7:0] I_LINE_DATA,
   input wire logic I_FIVE_ENDPOINT_MODE,
   // peripheral side effects
   output logic O_VECTOR_CLEAR,
   output logic O_WATCHDOG_RESTART,
   output logic O_WR_PULSE,
   output logic [7:0] O_WR_ADDR,
   output logic [7:0] O_WR_DATA,
   // register contents
   output logic [31:0] O_PORT_IRQ_ENABLE,
   output logic [7:0] O_SECOND_DEVICE_ADDRESS,
   output logic [7:0] O_SECOND_EP0_MODE,
   output logic [7:0] O_SECOND_EP1_MODE,
   output logic [7:0] O_FIRST_EP3_MODE,
   output logic [7:0] O_FIRST_EP4_MODE,
   output logic [7:0] O_CONTROL_LOW_PORTS,
   output logic [7:0] O_CONTROL_HIGH_PORTS,
   output logic [7:0] O_DRIVE_LOW,
   output logic [7:0] O_DRIVE_HIGH,
   output logic [7:0] O_PROCESSOR_STATUS
);

   logic [7:0] slot_reg [NUM_SLOTS];
   logic [3:0] timer_hold_reg;
   logic [3:0] timer_hold_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic vector_clear_reg;
   logic watchdog_reg;
   logic wr_pulse_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_data_reg;

   // one request per cycle; a read wins, then a direct write, then an indexed write
   wire rd_req = I_PORT_READ_INSTRUCTION;
   wire wr_req = I_PORT_WRITE_INSTRUCTION && !rd_req;
   wire wrx_req = I_INDEXED_PORT_WRITE_INSTRUCTION && !rd_req && !I_PORT_WRITE_INSTRUCTION;
   wire any_wr = wr_req || wrx_req;

   // 8-bit sum wraps; a zero operand leaves the index alone
   wire [7:0] indexed_addr = 8'(I_INDEX + I_ADDR);
   wire [7:0] eff_addr = wrx_req ? indexed_addr : I_ADDR;

   wire [NUM_SLOTS-1:0] slot_hit;
   wire [NUM_SLOTS-1:0] slot_wr;
   wire [NUM_SLOTS-1:0] slot_readable;
   wire [7:0] slot_or [NUM_SLOTS+1];
   assign slot_or[0] = 8'h00;

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
         assign slot_hit[g] = (eff_addr == SLOT_ADDR[g]);
         // port interrupt enables are write only and the second address is dead in 5-ep mode
         assign slot_readable[g] = !(g >= SLOT_PORT0_IRQ_ENABLE && g <= SLOT_PORT3_IRQ_ENABLE)
            && !(g == SLOT_DEVICE_ADDRESS_SECOND && I_FIVE_ENDPOINT_MODE);
         assign slot_wr[g] = any_wr && slot_hit[g]
            && !(g == SLOT_DEVICE_ADDRESS_SECOND && I_FIVE_ENDPOINT_MODE);
         assign slot_or[g+1] = slot_or[g]
            | ((rd_req && slot_hit[g] && slot_readable[g]) ? slot_reg[g] : 8'h00);
      end
   endgenerate

   // status registers and the watchdog restart address outside the slot store
   wire hit_vector = (eff_addr == PENDING_VECTOR_ADDR);
   wire hit_timer_low = (eff_addr == TIMER_LOW_BYTE_ADDR);
   wire hit_timer_high = (eff_addr == TIMER_HIGH_NIBBLE_ADDR);
   wire hit_watchdog = (eff_addr == WATCHDOG_RESTART_ADDR);
   wire hit_resume = (eff_addr == DOWNSTREAM_RESUME_STATUS_ADDR);
   wire hit_se0 = (eff_addr == DOWNSTREAM_SINGLE_ENDED_ZERO_ADDR);
   wire hit_line = (eff_addr == DOWNSTREAM_LINE_DATA_ADDR);

   // status registers take no writes, and undefined addresses read zero
   wire [7:0] status_rdata =
      hit_vector ? I_PENDING_VECTOR :
      hit_timer_low ? I_TIMER[7:0] :
      hit_timer_high ? {4'h0, timer_hold_reg} :
      hit_resume ? I_RESUME_STATUS :
      hit_se0 ? I_SINGLE_ENDED_ZERO :
      hit_line ? I_LINE_DATA : 8'h00;

   assign rdata_next = rd_req ? (slot_or[NUM_SLOTS] | status_rdata) : rdata_reg;
   // the latch keeps the high nibble coherent with the low byte just read
   assign timer_hold_next = (rd_req && hit_timer_low) ? I_TIMER[11:8] : timer_hold_reg;
   wire wr_mapped = |slot_wr;

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            slot_reg[i] <= REGISTER_RESET_VALUE;
         end
      end else begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_wr[i]) begin
               slot_reg[i] <= I_ACC;
            end
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rdata_reg <= REGISTER_RESET_VALUE;
         rvalid_reg <= 1'b0;
         timer_hold_reg <= TIMER_HOLD_RESET_VALUE;
         vector_clear_reg <= 1'b0;
         watchdog_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rd_req;
         timer_hold_reg <= timer_hold_next;
         vector_clear_reg <= rd_req && hit_vector;
         watchdog_reg <= any_wr && hit_watchdog;
      end
   end

   // write notice for peripheral logic that tracks firmware writes
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         wr_pulse_reg <= 1'b0;
         wr_addr_reg <= REGISTER_RESET_VALUE;
         wr_data_reg <= REGISTER_RESET_VALUE;
      end else begin
         wr_pulse_reg <= wr_mapped;
         if (wr_mapped) begin
            wr_addr_reg <= eff_addr;
            wr_data_reg <= I_ACC;
         end
      end
   end

   assign O_RDATA = rdata_reg;
   assign O_RDATA_VALID = rvalid_reg;
   assign O_VECTOR_CLEAR = vector_clear_reg;
   assign O_WATCHDOG_RESTART = watchdog_reg;
   assign O_WR_PULSE = wr_pulse_reg;
   assign O_WR_ADDR = wr_addr_reg;
   assign O_WR_DATA = wr_data_reg;
   assign O_PORT_IRQ_ENABLE = {slot_reg[SLOT_PORT3_IRQ_ENABLE],
      slot_reg[SLOT_PORT0_IRQ_ENABLE+2], slot_reg[SLOT_PORT0_IRQ_ENABLE+1],
      slot_reg[SLOT_PORT0_IRQ_ENABLE]};

   // 5-ep mode hands the second address's mode registers to endpoints 3 and 4
   wire five_ep = I_FIVE_ENDPOINT_MODE;
   assign O_SECOND_DEVICE_ADDRESS = five_ep ? 8'h00 : slot_reg[SLOT_DEVICE_ADDRESS_SECOND];
   assign O_SECOND_EP0_MODE = five_ep ? 8'h00 : slot_reg[SLOT_SECOND_EP0_MODE];
   assign O_SECOND_EP1_MODE = five_ep ? 8'h00 : slot_reg[SLOT_SECOND_EP1_MODE];
   assign O_FIRST_EP3_MODE = five_ep ? slot_reg[SLOT_SECOND_EP0_MODE] : 8'h00;
   assign O_FIRST_EP4_MODE = five_ep ? slot_reg[SLOT_SECOND_EP1_MODE] : 8'h00;
   assign O_CONTROL_LOW_PORTS = slot_reg[SLOT_CONTROL_LOW_PORTS];
   assign O_CONTROL_HIGH_PORTS = slot_reg[SLOT_CONTROL_HIGH_PORTS];
   assign O_DRIVE_LOW = slot_reg[SLOT_DRIVE_LOW];
   assign O_DRIVE_HIGH = slot_reg[SLOT_DRIVE_HIGH];
   assign O_PROCESSOR_STATUS = slot_reg[SLOT_PROCESSOR_STATUS];

   a_read_valid: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_req |=> O_RDATA_VALID ##1 (O_RDATA_VALID == $past(rd_req)))
      else $error("read answer did not follow the read");

   a_write_top_reg: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == PROCESSOR_STATUS_CONTROL_ADDR)
      |=> O_PROCESSOR_STATUS == $past(I_ACC) && O_WR_PULSE && O_WR_ADDR == 8'hff)
      else $error("direct write did not store accumulator");

   a_indexed_sum: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wrx_req && 8'(I_INDEX + I_ADDR) == PROCESSOR_STATUS_CONTROL_ADDR)
      |=> O_PROCESSOR_STATUS == $past(I_ACC))
      else $error("indexed write missed the summed address");

   a_index_alone: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wrx_req && I_ADDR == 8'h00) |=> (!O_WR_PULSE || O_WR_ADDR == $past(I_INDEX)))
      else $error("zero operand did not select by index alone");

   a_irq_en_wo: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == PORT2_IRQ_ENABLE_ADDR) ##1 (rd_req && I_ADDR == PORT2_IRQ_ENABLE_ADDR)
      |=> O_PORT_IRQ_ENABLE[23:16] == $past(I_ACC, 2) && O_RDATA == 8'h00)
      else $error("interrupt enable write failed or read back");

   a_vector_clear: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == PENDING_VECTOR_ADDR)
      |=> O_VECTOR_CLEAR && O_RDATA == $past(I_PENDING_VECTOR) ##1 !O_VECTOR_CLEAR
         || $past(rd_req))
      else $error("vector read did not return and clear");

   a_timer_low: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == TIMER_LOW_BYTE_ADDR) |=> O_RDATA == $past(I_TIMER[7:0]))
      else $error("timer low byte wrong");

   a_timer_latch: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == TIMER_LOW_BYTE_ADDR) ##1 (rd_req && I_ADDR == TIMER_HIGH_NIBBLE_ADDR)
      |=> O_RDATA == {4'h0, $past(I_TIMER[11:8], 2)})
      else $error("timer high read not from latch");

   a_watchdog_pulse: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (any_wr && eff_addr == WATCHDOG_RESTART_ADDR) |=> O_WATCHDOG_RESTART ##1
         (O_WATCHDOG_RESTART == $past(any_wr && eff_addr == WATCHDOG_RESTART_ADDR)))
      else $error("watchdog restart pulse wrong");

   a_five_ep_map: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (I_FIVE_ENDPOINT_MODE && wr_req && I_ADDR == SECOND_EP1_MODE_ADDR)
      ##1 I_FIVE_ENDPOINT_MODE
      |-> O_FIRST_EP4_MODE == $past(I_ACC) && O_SECOND_DEVICE_ADDRESS == 8'h00)
      else $error("five-endpoint mapping wrong");

   a_ctrl_split: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == DOWNSTREAM_CONTROL_HIGH_PORTS_ADDR)
      |=> O_CONTROL_HIGH_PORTS == $past(I_ACC) && $stable(O_CONTROL_LOW_PORTS))
      else $error("control split broken");

   a_status_ro: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (any_wr && (hit_resume || hit_se0 || hit_line)) |=> !O_WR_PULSE)
      else $error("read-only status accepted a write");

   a_force_rw: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == DOWNSTREAM_DRIVE_HIGH_ADDR)
      ##1 (rd_req && I_ADDR == DOWNSTREAM_DRIVE_HIGH_ADDR)
      |=> O_RDATA == $past(I_ACC, 2))
      else $error("force register did not read back");

   a_reserved_zero: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == 8'h30) |=> O_RDATA == 8'h00)
      else $error("reserved address read not zero");

   a_reserved_nowr: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (any_wr && eff_addr == 8'h3f) |=> !O_WR_PULSE && $stable(O_PROCESSOR_STATUS))
      else $error("reserved write had an effect");

   a_rvalid_idle: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      !rd_req |=> !O_RDATA_VALID)
      else $error("read valid without a read");

   a_rdata_hold: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      !rd_req |=> $stable(O_RDATA))
      else $error("read data moved without a read");

   a_proc_readback: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == PROCESSOR_STATUS_CONTROL_ADDR)
      |=> O_RDATA == $past(O_PROCESSOR_STATUS))
      else $error("processor status read wrong");

   a_write_data: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == DOWNSTREAM_CONTROL_LOW_PORTS_ADDR)
      |=> O_CONTROL_LOW_PORTS == $past(I_ACC) && O_WR_DATA == $past(I_ACC))
      else $error("direct write data wrong");

   a_indexed_notice: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wrx_req && indexed_addr == DOWNSTREAM_CONTROL_HIGH_PORTS_ADDR)
      |=> O_WR_PULSE && O_WR_ADDR == DOWNSTREAM_CONTROL_HIGH_PORTS_ADDR)
      else $error("indexed write notice wrong");

   a_zero_operand: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wrx_req && I_ADDR == 8'h00 && I_INDEX == DOWNSTREAM_CONTROL_LOW_PORTS_ADDR)
      |=> O_CONTROL_LOW_PORTS == $past(I_ACC))
      else $error("zero operand write missed the index target");

   a_irq_en_rd_zero: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR >= PORT0_IRQ_ENABLE_ADDR && I_ADDR <= PORT3_IRQ_ENABLE_ADDR)
      |=> O_RDATA == 8'h00)
      else $error("interrupt enable read not zero");

   a_vector_quiet: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      !(rd_req && hit_vector) |=> !O_VECTOR_CLEAR)
      else $error("vector clear without a vector read");

   a_timer_hold_keep: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      !(rd_req && hit_timer_low) |=> $stable(timer_hold_reg))
      else $error("timer latch moved without a low read");

   a_timer_ro: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (any_wr && (hit_timer_low || hit_timer_high || hit_vector)) |=> !O_WR_PULSE)
      else $error("timer or vector accepted a write");

   a_watchdog_quiet: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      !(any_wr && hit_watchdog) |=> !O_WATCHDOG_RESTART)
      else $error("watchdog restart without a write");

   a_watchdog_rd_zero: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == WATCHDOG_RESTART_ADDR) |=> O_RDATA == 8'h00)
      else $error("watchdog address read not zero");

   a_second_addr_dead: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (I_FIVE_ENDPOINT_MODE && any_wr && eff_addr == DEVICE_ADDRESS_SECOND_ADDR)
      |=> !O_WR_PULSE)
      else $error("second address took a write in five-endpoint mode");

   a_ctrl_low_only: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == DOWNSTREAM_CONTROL_LOW_PORTS_ADDR) |=> $stable(O_CONTROL_HIGH_PORTS))
      else $error("low ports write touched high ports");

   a_line_data_read: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (rd_req && I_ADDR == DOWNSTREAM_LINE_DATA_ADDR) |=> O_RDATA == $past(I_LINE_DATA))
      else $error("line data read wrong");

   a_force_low_rw: assert property (
      @(posedge I_MCLK) disable iff (!I_RESETN)
      (wr_req && I_ADDR == DOWNSTREAM_DRIVE_LOW_ADDR)
      |=> O_DRIVE_LOW == $past(I_ACC) && $stable(O_DRIVE_HIGH))
      else $error("force low write wrong");

endmodule // io_port_address_decoder

// *** dv/core_model.sv ***
`timescale 1ns/10ps
module core_model (
   // clock
   input wire logic i_mclk,
   // instruction strobes and operands
   output logic o_rd,
   output logic o_wr,
   output logic o_wrx,
   output logic [7:0] o_addr,
   output logic [7:0] o_index,
   output logic [7:0] o_acc,
   // read answer
   input wire logic [7:0] i_rdata,
   input wire logic i_rdata_valid
);
   logic [7:0] last_rdata;
   logic last_valid;

   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wrx = 1'b0;
      o_addr = 8'h00;
      o_index = 8'h00;
      o_acc = 8'h00;
   end

   // idle operands flip so that a stale value can never pass for a live one
   task automatic release_bus();
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_wrx <= 1'b0;
      o_addr <= ~o_addr;
      o_index <= ~o_index;
      o_acc <= ~o_acc;
   endtask

   task automatic io_read(input logic [7:0] addr);
      @(posedge i_mclk);
      o_rd <= 1'b1;
      o_addr <= addr;
      @(posedge i_mclk);
      release_bus();
      #1;
      last_rdata = i_rdata;
      last_valid = i_rdata_valid;
   endtask

   // reserved addresses and non-zero reserved bits only go out when the bench asks
   task automatic io_write(input logic indexed, input logic [7:0] index, addr, data);
      @(posedge i_mclk);
      o_wr <= ~indexed;
      o_wrx <= indexed;
      o_index <= index;
      o_addr <= addr;
      o_acc <= data;
      @(posedge i_mclk);
      release_bus();
      #1;
   endtask
endmodule // core_model

// *** dv/test_io_port_address_decoder.sv ***
`timescale 1ns/10ps
module test_io_port_address_decoder import io_port_pkg::*; ;
   logic mclk, resetn, five_ep, rd, wr, wrx, rvalid, vclr, wdog, wpulse;
   logic [7:0] vector, res_st, se0, line, addr, index, acc, rdata, waddr, wdata;
   logic [7:0] sec_addr, sec_ep0, sec_ep1, ep3, ep4, ctl_lo, ctl_hi, drv_lo, drv_hi, pstat;
   logic [7:0] a, e;
   logic [11:0] timer;
   logic [31:0] irq_en;
   logic [7:0] ro [6] = '{8'h23, 8'h24, 8'h25, 8'h4e, 8'h4f, 8'h50};
   logic [7:0] undef [8] = '{8'h17, 8'h22, 8'h27, 8'h30, 8'h3f, 8'h53, 8'h80, 8'hfe};
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   core_model core (.i_mclk(mclk), .o_rd(rd), .o_wr(wr), .o_wrx(wrx), .o_addr(addr),
      .o_index(index), .o_acc(acc), .i_rdata(rdata), .i_rdata_valid(rvalid));

   io_port_address_decoder dut (.I_MCLK(mclk), .I_RESETN(resetn),
      .I_PORT_READ_INSTRUCTION(rd), .I_PORT_WRITE_INSTRUCTION(wr),
      .I_INDEXED_PORT_WRITE_INSTRUCTION(wrx), .I_ADDR(addr), .I_INDEX(index), .I_ACC(acc),
      .O_RDATA(rdata), .O_RDATA_VALID(rvalid), .I_PENDING_VECTOR(vector), .I_TIMER(timer),
      .I_RESUME_STATUS(res_st), .I_SINGLE_ENDED_ZERO(se0), .I_LINE_DATA(line),
      .I_FIVE_ENDPOINT_MODE(five_ep), .O_VECTOR_CLEAR(vclr), .O_WATCHDOG_RESTART(wdog),
      .O_WR_PULSE(wpulse), .O_WR_ADDR(waddr), .O_WR_DATA(wdata), .O_PORT_IRQ_ENABLE(irq_en),
      .O_SECOND_DEVICE_ADDRESS(sec_addr), .O_SECOND_EP0_MODE(sec_ep0),
      .O_SECOND_EP1_MODE(sec_ep1), .O_FIRST_EP3_MODE(ep3), .O_FIRST_EP4_MODE(ep4),
      .O_CONTROL_LOW_PORTS(ctl_lo), .O_CONTROL_HIGH_PORTS(ctl_hi), .O_DRIVE_LOW(drv_lo),
      .O_DRIVE_HIGH(drv_hi), .O_PROCESSOR_STATUS(pstat));

   always #2 mclk = ~mclk;

   task automatic check(input string what, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a_in, exp);
      core.io_read(a_in);
      check(what, core.last_rdata, exp);
      check("read valid", {7'h0, core.last_valid}, 8'h01);
   endtask

   task automatic done_test(input string name);
      $display("test %s done, comparisons %0d, mismatches %0d", name, comparisons, fails);
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      five_ep = 1'b0;
      vector = 8'h00;
      timer = 12'h000;
      res_st = 8'h00;
      se0 = 8'h00;
      line = 8'h00;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         a = SLOT_ADDR[i];
         rd_chk("reset value", a, REGISTER_RESET_VALUE);
         core.io_write(1'b0, 8'h00, a, a ^ 8'ha5);
         check("write pulse", {7'h0, wpulse}, 8'h01);
         check("write addr", waddr, a);
         check("write data", wdata, a ^ 8'ha5);
      end
      for (int i = 0; i < NUM_SLOTS; i++) begin
         a = SLOT_ADDR[i];
         e = (i >= SLOT_PORT0_IRQ_ENABLE && i <= SLOT_PORT3_IRQ_ENABLE) ? 8'h00 : a ^ 8'ha5;
         rd_chk("read back", a, e);
      end
      for (int i = 0; i < 4; i++) begin
         check("irq enable", irq_en[i*8 +: 8], (8'h04 + 8'(i)) ^ 8'ha5);
      end
      check("ctl low ports", ctl_lo, 8'h4b ^ 8'ha5);
      check("ctl high ports", ctl_hi, 8'h4c ^ 8'ha5);
      check("drive low", drv_lo, 8'h51 ^ 8'ha5);
      check("drive high", drv_hi, 8'h52 ^ 8'ha5);
      check("proc status", pstat, 8'hff ^ 8'ha5);
      done_test("register map");

      @(posedge mclk);
      vector <= 8'h2c;
      timer <= 12'habc;
      res_st <= 8'h3c;
      se0 <= 8'h0f;
      line <= 8'h96;
      rd_chk("vector", 8'h23, 8'h2c);
      check("vector clear", {7'h0, vclr}, 8'h01);
      rd_chk("timer low", 8'h24, 8'hbc);
      check("no vector clear", {7'h0, vclr}, 8'h00);
      @(posedge mclk);
      timer <= 12'h5de;
      rd_chk("timer high", 8'h25, 8'h0a);
      rd_chk("timer low", 8'h24, 8'hde);
      rd_chk("timer high", 8'h25, 8'h05);
      foreach (ro[i]) begin
         core.io_write(1'b0, 8'h00, ro[i], 8'hff);
         check("refused pulse", {7'h0, wpulse}, 8'h00);
      end
      rd_chk("resume", 8'h4e, 8'h3c);
      rd_chk("se0", 8'h4f, 8'h0f);
      rd_chk("line data", 8'h50, 8'h96);
      rd_chk("timer held", 8'h25, 8'h05);
      core.io_write(1'b0, 8'h00, 8'h26, 8'h00);
      check("watchdog", {7'h0, wdog}, 8'h01);
      core.io_write(1'b1, 8'h20, 8'h06, 8'h00);
      check("watchdog", {7'h0, wdog}, 8'h01);
      rd_chk("watchdog read", 8'h26, 8'h00);
      done_test("status and side effects");

      core.io_write(1'b1, 8'hfe, 8'h01, 8'h3e);
      check("proc status", pstat, 8'h3e);
      core.io_write(1'b1, 8'h4b, 8'h00, 8'h1d);
      check("ctl low ports", ctl_lo, 8'h1d);
      core.io_write(1'b1, 8'hf0, 8'h5c, 8'h07);
      check("ctl high ports", ctl_hi, 8'h07);
      check("write addr", waddr, 8'h4c);
      done_test("indexed write");

      @(posedge mclk);
      five_ep <= 1'b1;
      core.io_write(1'b0, 8'h00, 8'h42, 8'h33);
      core.io_write(1'b0, 8'h00, 8'h44, 8'h44);
      check("ep3 mode", ep3, 8'h33);
      check("ep4 mode", ep4, 8'h44);
      check("second ep0", sec_ep0, 8'h00);
      check("second ep1", sec_ep1, 8'h00);
      check("second addr", sec_addr, 8'h00);
      core.io_write(1'b0, 8'h00, 8'h40, 8'h77);
      check("refused pulse", {7'h0, wpulse}, 8'h00);
      rd_chk("second addr", 8'h40, 8'h00);
      @(posedge mclk);
      five_ep <= 1'b0;
      rd_chk("second addr", 8'h40, 8'h40 ^ 8'ha5);
      check("second ep0", sec_ep0, 8'h33);
      check("ep3 mode", ep3, 8'h00);
      done_test("five endpoint mode");

      foreach (undef[i]) begin
         core.io_write(1'b0, 8'h00, undef[i], 8'h5a);
         check("undefined pulse", {7'h0, wpulse}, 8'h00);
         rd_chk("undefined", undef[i], 8'h00);
      end
      rd_chk("proc status", 8'hff, 8'h3e);
      done_test("undefined addresses");
      complete_run();
   end
endmodule // test_io_port_address_decoder
